// *** logic/fsp_pkg.sv ***
// Shared constants, field positions and carrier types of the flash status and protection block.
package fsp_pkg;

  // Command opcodes taken from the serial link.
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_VOLATILE_ENABLE = 8'h50;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;

  // Status byte positions, normal view.
  localparam int SB_BUSY = 0;
  localparam int SB_WEL = 1;
  localparam int SB_PROT_LO = 2;
  localparam int SB_PROT_HI = 7;
  // Status byte positions, OTP view.
  localparam int SB_OTP_RSVD = 2;
  localparam int SB_OTP_LO = 3;
  localparam int SB_OTP_HI = 7;

  // Values after power-up.
  localparam logic [5:0] NV_PROT_RESET = 6'h00;
  localparam logic [4:0] OTP_NV_RESET = 5'h00;

  // Frame bit counts.
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] CMD_DATA_BITS = 5'h10;
  localparam logic [4:0] BIT_CNT_MAX = 5'h11;

  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int VOLATILE_UPDATE_TIME_NS = 50;
  localparam int VOLATILE_UPDATE_CYCLES =
    (VOLATILE_UPDATE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : VOLATILE_UPDATE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] STATUS_WRITE_CYCLES = 16'h0064;

  // Array geometry used by the protection check.
  localparam logic [8:0] ARRAY_BLOCKS = 9'h100;
  localparam logic [3:0] BP_ALL_CODE = 4'h9;

  typedef enum logic [2:0] {
    OP_PAGE_PROGRAM,
    OP_QUAD_PAGE_PROGRAM,
    OP_SECTOR_ERASE,
    OP_HALF_BLOCK_ERASE,
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE
  } fsp_op_kind_t;

  typedef enum logic [1:0] {
    PIN_HOLD,
    PIN_RESET,
    PIN_DATA_IO
  } fsp_pin_mode_t;

  typedef enum logic {
    SWR_IDLE,
    SWR_BUSY
  } fsp_swr_state_t;

  typedef struct packed {
    logic valid;
    fsp_op_kind_t kind;
    logic otp_sector;
    logic [23:0] addr;
  } fsp_op_req_t;

  typedef struct packed {
    logic grant;
    logic reject;
  } fsp_op_ans_t;

endpackage : fsp_pkg

// *** logic/fsp_protect.sv ***
// Address check against the block-protect region and the boot-lock region.
`timescale 1ns/100ps
module fsp_protect
  import fsp_pkg::*;
(
  // Protection settings
  input wire logic [3:0] block_protect_in,
  input wire logic top_bottom_select_in,
  input wire logic boot_lock_enable_in,
  input wire logic boot_lock_size_in,
  // Target
  input wire logic [23:0] addr_in,
  output logic blocked_out
);

  logic [8:0] nblk;
  logic [8:0] blk;
  logic bp_hit;
  logic boot_hit;

  // The region grows by powers of two 64KB blocks: codes 1 to 8 give 1 to 128 blocks, code 9 and up the whole array.
  always_comb begin
    nblk = 9'h000;
    if (block_protect_in >= BP_ALL_CODE) begin
      nblk = ARRAY_BLOCKS;
    end else if (block_protect_in != 4'h0) begin
      nblk = 9'(9'h001 << (block_protect_in - 4'h1));
    end
    blk = {1'b0, addr_in[23:16]};
    if (top_bottom_select_in) begin
      bp_hit = blk < nblk;
    end else begin
      bp_hit = blk >= 9'(ARRAY_BLOCKS - nblk);
    end
  end

  always_comb begin
    if (boot_lock_size_in) begin
      boot_hit = top_bottom_select_in ? (addr_in[23:12] == 12'h000) : (addr_in[23:12] == 12'hfff);
    end else begin
      boot_hit = top_bottom_select_in ? (addr_in[23:16] == 8'h00) : (addr_in[23:16] == 8'hff);
    end
    blocked_out = (bp_hit && block_protect_in != 4'h0) || (boot_lock_enable_in && boot_hit);
  end

endmodule : fsp_protect

// *** logic/fsp_sync.sv ***
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/100ps
module fsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : fsp_sync

// *** logic/fsp_top.sv ***
// Status register, write-enable latch and write-protect qualification of a serial flash.
// Behaviour
// - Volatile-enable command leaves the latch alone; a status write in the very next frame updates volatile bits.
// - A volatile status write updates protection bits 7..2, or OTP bits 6..3 in OTP mode, right after deselect.
// - Software or pin reset reloads volatile bits from their non-volatile copies.
// - Write-disable clears the latch, or in OTP mode returns to normal mode.
// - Latch clears at power-up and when non-volatile status write, program or erase completes.
// - Status read works anytime and repeats the current value while selected.
// - Bit 0 is busy: one during status write, program or erase cycles.
// - Bit 1 shows the latch; without it non-volatile status writes, programs and erases are rejected.
// - Block-protect bits pick a region where program and erase are blocked.
// - Chip erase runs only with all block-protect bits and boot-lock enable zero.
// - Boot-lock enable locks the sector or block chosen by top/bottom and size.
// - Protect bit set with protect pin low freezes bits and refuses status writes.
// - Top/bottom select places regions at top when zero, bottom when one.
// - Boot-lock size selects 4KB sector when one, 64KB block when zero.
// - Pin-disable bit turns off protect and hold/reset pins; quad mode does too.
// - Hold/reset select makes shared pin hold or reset while pins are enabled.
// - OTP lock set once by status write blocks OTP program and erase forever.
// - OTP view maps lock, pin disable, hold/reset, size, top/bottom, 0, latch, busy.
// - Busy in the status read equals the busy bit of the second status register.
// - Write-enable command sets the latch needed by every write instruction except a volatile status write.
// - Deselect after a valid non-volatile status write starts a timed busy cycle, then clears latch.
`timescale 1ns/100ps
module fsp_top
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Serial link pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Protect and shared hold/reset pins
  input wire logic wp_n_in,
  input wire logic hold_reset_n_in,
  // Mode and reset events from the command decoder
  input wire logic quad_mode_in,
  input wire logic otp_mode_enter_in,
  input wire logic soft_reset_in,
  // Program and erase engine
  input wire fsp_op_req_t op_req_in,
  output fsp_op_ans_t op_ans_out,
  input wire logic engine_busy_in,
  input wire logic op_done_in,
  // Status and pin-function outputs
  output logic [7:0] status_out,
  output logic busy_out,
  output logic otp_mode_out,
  output fsp_pin_mode_t pin_mode_out,
  output logic hold_active_out,
  output logic device_reset_out
);

  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic wp_n_s;
  logic hold_reset_n_s;

  fsp_sync #(
    .WIDTH(5),
    .RESET_VALUE(5'h0b)
  ) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in({sclk_in, cs_n_in, mosi_in, wp_n_in, hold_reset_n_in}),
    .sync_out({sclk_s, cs_n_s, mosi_s, wp_n_s, hold_reset_n_s})
  );

  function automatic logic frame_is(input logic [4:0] cnt, input logic [15:0] sh,
                                    input logic [7:0] opc, input logic with_data);
    if (with_data) begin
      frame_is = (cnt == CMD_DATA_BITS) && (sh[15:8] == opc);
    end else begin
      frame_is = (cnt == CMD_BITS) && (sh[7:0] == opc);
    end
  endfunction : frame_is

  // Control state.
  logic [5:0] nv_prot_q, nv_prot_d;
  logic [5:0] vol_prot_q, vol_prot_d;
  logic [4:0] otp_nv_q, otp_nv_d;
  logic [3:0] otp_vol_q, otp_vol_d;
  logic write_enable_latch_q, write_enable_latch_d;
  logic vol_en_q, vol_en_d;
  logic otp_mode_q, otp_mode_d;
  fsp_swr_state_t swr_state_q, swr_state_d;
  logic [15:0] swr_cnt_q, swr_cnt_d;
  logic [7:0] swr_data_q, swr_data_d;
  logic swr_otp_q, swr_otp_d;
  fsp_op_ans_t ans_q, ans_d;
  logic [7:0] status_q, status_d;
  logic busy_q, busy_d;
  fsp_pin_mode_t pin_mode_q, pin_mode_d;
  logic hold_q, hold_d;
  logic rst_q, rst_d;

  // Frame state.
  logic sclk_prev_q, sclk_prev_d;
  logic cs_prev_q, cs_prev_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic [7:0] tx_q, tx_d;
  logic [2:0] txcnt_q, txcnt_d;
  logic miso_q, miso_d;
  logic miso_oe_q, miso_oe_d;

  // Effective fields.
  logic [3:0] block_protect;
  logic boot_lock_enable;
  logic status_protect_bit;
  logic top_bottom_select;
  logic boot_lock_size;
  logic hold_reset_pin_select;
  logic control_pins_disable;
  logic otp_lock;
  logic write_in_progress;
  logic pins_enabled;
  fsp_pin_mode_t pin_mode;
  logic hw_protected;
  logic any_reset;
  logic hold_now;
  logic frame_end;
  logic prot_blocked;
  logic [7:0] status_view;

  always_comb begin
    block_protect = vol_prot_q[3:0];
    boot_lock_enable = vol_prot_q[4];
    status_protect_bit = vol_prot_q[5];
    top_bottom_select = otp_vol_q[0];
    boot_lock_size = otp_vol_q[1];
    hold_reset_pin_select = otp_vol_q[2];
    control_pins_disable = otp_vol_q[3];
    otp_lock = otp_nv_q[4];
    write_in_progress = (swr_state_q == SWR_BUSY) || engine_busy_in;
    pins_enabled = !control_pins_disable && !quad_mode_in;
    if (!pins_enabled) begin
      pin_mode = PIN_DATA_IO;
    end else if (hold_reset_pin_select) begin
      pin_mode = PIN_RESET;
    end else begin
      pin_mode = PIN_HOLD;
    end
    // The protect pin only counts while the pin functions are enabled.
    hw_protected = status_protect_bit && !wp_n_s && pins_enabled;
    any_reset = soft_reset_in || (pin_mode == PIN_RESET && !hold_reset_n_s);
    hold_now = (pin_mode == PIN_HOLD) && !hold_reset_n_s;
    frame_end = cs_n_s && !cs_prev_q;
    if (otp_mode_q) begin
      status_view = {otp_lock, control_pins_disable, hold_reset_pin_select, boot_lock_size,
                     top_bottom_select, 1'b0, write_enable_latch_q, write_in_progress};
    end else begin
      status_view = {vol_prot_q, write_enable_latch_q, write_in_progress};
    end
  end

  fsp_protect u_protect (
    .block_protect_in(block_protect),
    .top_bottom_select_in(top_bottom_select),
    .boot_lock_enable_in(boot_lock_enable),
    .boot_lock_size_in(boot_lock_size),
    .addr_in(op_req_in.addr),
    .blocked_out(prot_blocked)
  );

  always_comb begin
    nv_prot_d = nv_prot_q;
    vol_prot_d = vol_prot_q;
    otp_nv_d = otp_nv_q;
    otp_vol_d = otp_vol_q;
    write_enable_latch_d = write_enable_latch_q;
    vol_en_d = vol_en_q;
    otp_mode_d = otp_mode_q || otp_mode_enter_in;
    swr_state_d = swr_state_q;
    swr_cnt_d = swr_cnt_q;
    swr_data_d = swr_data_q;
    swr_otp_d = swr_otp_q;
    ans_d = '0;
    // Completions clear the latch first so a write-enable in the same cycle still sets it.
    if (op_done_in) begin
      write_enable_latch_d = 1'b0;
    end
    if (swr_state_q == SWR_BUSY) begin
      if (swr_cnt_q == 16'h0000) begin
        swr_state_d = SWR_IDLE;
        write_enable_latch_d = 1'b0;
        if (swr_otp_q) begin
          // OTP bits only program towards one and never back.
          otp_nv_d = otp_nv_q | swr_data_q[SB_OTP_HI:SB_OTP_LO];
          otp_vol_d = otp_vol_q | swr_data_q[SB_OTP_HI-1:SB_OTP_LO];
        end else begin
          nv_prot_d = swr_data_q[SB_PROT_HI:SB_PROT_LO];
          vol_prot_d = swr_data_q[SB_PROT_HI:SB_PROT_LO];
        end
      end else begin
        swr_cnt_d = swr_cnt_q - 16'h0001;
      end
    end
    if (op_req_in.valid) begin
      if (!write_enable_latch_q || write_in_progress) begin
        ans_d.reject = 1'b1;
      end else if (op_req_in.kind == OP_CHIP_ERASE) begin
        ans_d.grant = (block_protect == 4'h0) && !boot_lock_enable;
        ans_d.reject = !ans_d.grant;
      end else if (op_req_in.otp_sector) begin
        ans_d.grant = !otp_lock;
        ans_d.reject = otp_lock;
      end else begin
        ans_d.grant = !prot_blocked;
        ans_d.reject = prot_blocked;
      end
    end
    if (frame_end) begin
      vol_en_d = 1'b0;
      if (frame_is(cnt_q, sh_q, OPC_WRITE_ENABLE, 1'b0)) begin
        write_enable_latch_d = 1'b1;
      end else if (frame_is(cnt_q, sh_q, OPC_WRITE_DISABLE, 1'b0)) begin
        if (otp_mode_q) begin
          // An entry request in the same cycle wins over the exit.
          otp_mode_d = otp_mode_enter_in;
        end else begin
          write_enable_latch_d = 1'b0;
        end
      end else if (frame_is(cnt_q, sh_q, OPC_VOLATILE_ENABLE, 1'b0)) begin
        vol_en_d = 1'b1;
      end else if (frame_is(cnt_q, sh_q, OPC_STATUS_WRITE, 1'b1) &&
                   !write_in_progress && !hw_protected) begin
        if (vol_en_q) begin
          if (otp_mode_q) begin
            otp_vol_d = sh_q[SB_OTP_HI-1:SB_OTP_LO];
          end else begin
            vol_prot_d = sh_q[SB_PROT_HI:SB_PROT_LO];
          end
        end else if (write_enable_latch_q) begin
          swr_state_d = SWR_BUSY;
          swr_cnt_d = STATUS_WRITE_CYCLES - 16'h0001;
          swr_data_d = sh_q[7:0];
          swr_otp_d = otp_mode_q;
        end
      end
    end
    // A reset drops the volatile copies and aborts a status write in flight.
    if (any_reset) begin
      vol_prot_d = nv_prot_q;
      otp_vol_d = otp_nv_q[3:0];
      write_enable_latch_d = 1'b0;
      vol_en_d = 1'b0;
      otp_mode_d = 1'b0;
      swr_state_d = SWR_IDLE;
      ans_d = '0;
    end
    status_d = status_view;
    busy_d = write_in_progress;
    pin_mode_d = pin_mode;
    hold_d = hold_now;
    rst_d = any_reset;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv_prot_q <= NV_PROT_RESET;
      vol_prot_q <= NV_PROT_RESET;
      otp_nv_q <= OTP_NV_RESET;
      otp_vol_q <= OTP_NV_RESET[3:0];
      write_enable_latch_q <= 1'b0;
      vol_en_q <= 1'b0;
      otp_mode_q <= 1'b0;
      swr_state_q <= SWR_IDLE;
      swr_cnt_q <= 16'h0000;
      swr_data_q <= 8'h00;
      swr_otp_q <= 1'b0;
      ans_q <= '0;
      status_q <= 8'h00;
      busy_q <= 1'b0;
      pin_mode_q <= PIN_HOLD;
      hold_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      nv_prot_q <= nv_prot_d;
      vol_prot_q <= vol_prot_d;
      otp_nv_q <= otp_nv_d;
      otp_vol_q <= otp_vol_d;
      write_enable_latch_q <= write_enable_latch_d;
      vol_en_q <= vol_en_d;
      otp_mode_q <= otp_mode_d;
      swr_state_q <= swr_state_d;
      swr_cnt_q <= swr_cnt_d;
      swr_data_q <= swr_data_d;
      swr_otp_q <= swr_otp_d;
      ans_q <= ans_d;
      status_q <= status_d;
      busy_q <= busy_d;
      pin_mode_q <= pin_mode_d;
      hold_q <= hold_d;
      rst_q <= rst_d;
    end
  end

  // Frame shifter: mode 0, data in on rising edges, status out on falling edges.
  always_comb begin
    sclk_prev_d = sclk_s;
    cs_prev_d = cs_n_s;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    tx_d = tx_q;
    txcnt_d = txcnt_q;
    miso_d = miso_q;
    miso_oe_d = 1'b0;
    if (cs_n_s || any_reset) begin
      cnt_d = 5'h00;
      rd_d = 1'b0;
      txcnt_d = 3'h0;
    end else if (!hold_now) begin
      miso_oe_d = rd_q;
      if (sclk_s && !sclk_prev_q) begin
        sh_d = {sh_q[14:0], mosi_s};
        if (cnt_q != BIT_CNT_MAX) begin
          cnt_d = cnt_q + 5'h01;
        end
        if (cnt_q == CMD_BITS - 5'h01 && {sh_q[6:0], mosi_s} == OPC_STATUS_READ) begin
          rd_d = 1'b1;
        end
      end else if (!sclk_s && sclk_prev_q && rd_q) begin
        miso_oe_d = 1'b1;
        // Each new byte takes a fresh snapshot so busy can be polled in one frame.
        if (txcnt_q == 3'h0) begin
          miso_d = status_view[7];
          tx_d = {status_view[6:0], 1'b0};
        end else begin
          miso_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
        txcnt_d = txcnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      rd_q <= 1'b0;
      tx_q <= 8'h00;
      txcnt_q <= 3'h0;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      tx_q <= tx_d;
      txcnt_q <= txcnt_d;
      miso_q <= miso_d;
      miso_oe_q <= miso_oe_d;
    end
  end

  assign miso_out = miso_q;
  assign miso_oe_out = miso_oe_q;
  assign op_ans_out = ans_q;
  assign status_out = status_q;
  assign busy_out = busy_q;
  assign otp_mode_out = otp_mode_q;
  assign pin_mode_out = pin_mode_q;
  assign hold_active_out = hold_q;
  assign device_reset_out = rst_q;

endmodule : fsp_top

// *** tb/fsp_spi_host.sv ***
// Serial host model that frames commands and reads status on the link pins.
`timescale 1ns/100ps
module fsp_spi_host (
  // Link pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  localparam time HALF_NS = 400;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b1;
  end
  // Read data is taken late in the high phase, since the device answers through a synchroniser.
  task automatic bit_x(input logic b, output logic r);
    mosi_out = b;
    #HALF_NS;
    sclk_out = 1'b1;
    #HALF_NS;
    r = miso_in;
    sclk_out = 1'b0;
  endtask : bit_x
  task automatic shift8(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask : shift8
  // The odd start offset keeps link edges away from the system clock edges.
  task automatic begin_f;
    #37;
    cs_n_out = 1'b0;
  endtask : begin_f
  task automatic end_f;
    #HALF_NS;
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #(2 * HALF_NS);
  endtask : end_f
  task automatic cmd8(input logic [7:0] op);
    logic [7:0] rx;
    begin_f();
    shift8(op, rx);
    end_f();
  endtask : cmd8
  task automatic cmd16(input logic [7:0] op, input logic [7:0] data);
    logic [7:0] rx;
    begin_f();
    shift8(op, rx);
    shift8(data, rx);
    end_f();
  endtask : cmd16
  task automatic status_read_cmd(output logic [15:0] rd);
    logic [7:0] rx;
    begin_f();
    shift8(8'h05, rx);
    shift8(8'h00, rd[15:8]);
    shift8(8'h00, rd[7:0]);
    end_f();
  endtask : status_read_cmd
endmodule : fsp_spi_host

// *** tb/fsp_top_assertions.sv ***
// Port-level checks of the flash status and protection block.
`timescale 1ns/100ps
module fsp_top_assertions
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Observed inputs
  input wire logic cs_n_in,
  input wire logic quad_mode_in,
  input wire logic soft_reset_in,
  input wire logic engine_busy_in,
  input wire fsp_op_req_t op_req_in,
  // Observed outputs
  input wire fsp_op_ans_t op_ans_out,
  input wire logic miso_oe_out,
  input wire logic [7:0] status_out,
  input wire logic busy_out,
  input wire logic otp_mode_out,
  input wire fsp_pin_mode_t pin_mode_out,
  input wire logic device_reset_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Busy runs that involve the engine are excluded from the self-timed length check.
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic eng_q;
  logic eng_d;
  always_comb begin
    run_d = busy_out ? run_q + 8'h01 : 8'h00;
    eng_d = busy_out ? (eng_q | engine_busy_in) : engine_busy_in;
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_q <= 8'h00;
      eng_q <= 1'b0;
    end else begin
      run_q <= run_d;
      eng_q <= eng_d;
    end
  end

  sequence req_s;
    op_req_in.valid;
  endsequence
  sequence reset_ev_s;
    soft_reset_in ##1 device_reset_out;
  endsequence

  answer_once_a: assert property (req_s |=> op_ans_out.grant != op_ans_out.reject)
    else $error("op request not answered once");
  no_spurious_a: assert property (!op_req_in.valid |=> op_ans_out == 2'h0)
    else $error("op answer without request");
  latch_gate_a: assert property ((req_s ##1 !status_out[1]) |-> !op_ans_out.grant)
    else $error("grant without write latch");
  busy_gate_a: assert property ((req_s ##1 status_out[0]) |-> !op_ans_out.grant)
    else $error("grant while busy");
  chip_erase_a: assert property ((req_s ##0 op_req_in.kind == OP_CHIP_ERASE ##1
    (!otp_mode_out && status_out[6:2] != 5'h00)) |-> !op_ans_out.grant)
    else $error("chip erase granted while protected");
  busy_bit_a: assert property (busy_out == status_out[0])
    else $error("busy output differs from status bit 0");
  quad_pins_a: assert property (quad_mode_in [*2] |-> pin_mode_out == PIN_DATA_IO)
    else $error("pin functions active in quad mode");
  reset_event_a: assert property (soft_reset_in |-> reset_ev_s ##1
    (!status_out[1] && !otp_mode_out))
    else $error("soft reset did not clear latch and mode");
  write_cycle_a: assert property (($fell(busy_out) && !eng_q) |->
    (run_q >= 8'h62 && run_q <= 8'h66 && !status_out[1]))
    else $error("status write cycle length or latch wrong");
  oe_idle_a: assert property (cs_n_in [*6] |-> !miso_oe_out)
    else $error("data out driven while deselected");
endmodule : fsp_top_assertions

bind fsp_top fsp_top_assertions u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .cs_n_in(cs_n_in), .quad_mode_in(quad_mode_in), .soft_reset_in(soft_reset_in),
  .engine_busy_in(engine_busy_in), .op_req_in(op_req_in), .op_ans_out(op_ans_out),
  .miso_oe_out(miso_oe_out), .status_out(status_out), .busy_out(busy_out),
  .otp_mode_out(otp_mode_out), .pin_mode_out(pin_mode_out),
  .device_reset_out(device_reset_out));

// *** tb/tb_fsp_top.sv ***
// Self-checking bench for the flash status and protection block.
`timescale 1ns/100ps
module tb_fsp_top;
  import fsp_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic wp_n_in = 1'b1;
  logic hold_reset_n_in = 1'b1;
  logic op_otp = 1'b0;
  logic quad_mode_in = 1'b0;
  logic otp_mode_enter_in = 1'b0;
  logic soft_reset_in = 1'b0;
  logic engine_busy_in = 1'b0;
  logic op_done_in = 1'b0;
  fsp_op_req_t op_req_in = '0;
  fsp_op_ans_t op_ans_out;
  logic [7:0] status_out;
  logic busy_out, otp_mode_out, hold_active_out, device_reset_out;
  fsp_pin_mode_t pin_mode_out;
  int err_count = 0;
  int cmp_count = 0;

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  fsp_spi_host u_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  fsp_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .wp_n_in(wp_n_in),
    .hold_reset_n_in(hold_reset_n_in), .quad_mode_in(quad_mode_in),
    .otp_mode_enter_in(otp_mode_enter_in), .soft_reset_in(soft_reset_in),
    .op_req_in(op_req_in), .op_ans_out(op_ans_out), .engine_busy_in(engine_busy_in),
    .op_done_in(op_done_in), .status_out(status_out), .busy_out(busy_out),
    .otp_mode_out(otp_mode_out), .pin_mode_out(pin_mode_out),
    .hold_active_out(hold_active_out), .device_reset_out(device_reset_out));

  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t status got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // Host tasks end off the clock grid, so every command and status-write frame is followed by a realignment.
  task automatic cmd(input logic [7:0] op);
    u_host.cmd8(op);
    tick(4);
  endtask : cmd
  task automatic wr(input logic [7:0] data);
    u_host.cmd16(OPC_STATUS_WRITE, data);
    tick(4);
  endtask : wr
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk1(busy_out, 1'b0);
    if (busy_out !== 1'b0) begin
      conclude();
    end
  endtask : wait_idle
  // The answer stands for one cycle only, so it is judged before the request drops.
  task automatic op(input fsp_op_kind_t k, input logic [23:0] a, input logic g);
    op_req_in = '{valid: 1'b1, kind: k, otp_sector: op_otp, addr: a};
    tick(1);
    chk1(op_ans_out.grant, g);
    chk1(op_ans_out.reject, !g);
    op_req_in.valid = 1'b0;
    tick(1);
  endtask : op

  task automatic t_latch;
    chk8(status_out, 8'h00);
    chk1(pin_mode_out == PIN_HOLD, 1'b1);
    hold_reset_n_in = 1'b0;
    tick(3);
    chk1(hold_active_out, 1'b1);
    hold_reset_n_in = 1'b1;
    tick(3);
    op(OP_PAGE_PROGRAM, 24'h000000, 1'b0);
    cmd(OPC_WRITE_ENABLE);
    chk8(status_out, 8'h02);
    op(OP_SECTOR_ERASE, 24'h001000, 1'b1);
    engine_busy_in = 1'b1;
    tick(3);
    chk1(busy_out, 1'b1);
    engine_busy_in = 1'b0;
    op_done_in = 1'b1;
    tick(1);
    op_done_in = 1'b0;
    tick(2);
    chk8(status_out, 8'h00);
    cmd(OPC_WRITE_ENABLE);
    cmd(OPC_WRITE_DISABLE);
    chk8(status_out, 8'h00);
    $display("test latch done");
  endtask : t_latch
  task automatic t_nvw;
    logic [15:0] rd;
    cmd(OPC_WRITE_ENABLE);
    wr(8'h3c);
    chk1(busy_out, 1'b1);
    op(OP_PAGE_PROGRAM, 24'h000000, 1'b0);
    u_host.status_read_cmd(rd);
    chk8(rd[15:8], 8'h03);
    chk8(rd[7:0], 8'h3c);
    wait_idle();
    chk8(status_out, 8'h3c);
    cmd(OPC_WRITE_ENABLE);
    op(OP_CHIP_ERASE, 24'h000000, 1'b0);
    op(OP_PAGE_PROGRAM, 24'h000100, 1'b0);
    cmd(OPC_WRITE_DISABLE);
    $display("test status write done");
  endtask : t_nvw
  task automatic t_vol;
    cmd(OPC_VOLATILE_ENABLE);
    chk8(status_out, 8'h3c);
    wr(8'h00);
    chk8(status_out, 8'h00);
    soft_reset_in = 1'b1;
    tick(1);
    soft_reset_in = 1'b0;
    tick(3);
    chk8(status_out, 8'h3c);
    $display("test volatile done");
  endtask : t_vol
  task automatic t_hwp;
    cmd(OPC_WRITE_ENABLE);
    wr(8'hbc);
    wait_idle();
    wp_n_in = 1'b0;
    cmd(OPC_WRITE_ENABLE);
    wr(8'h00);
    chk8(status_out, 8'hbe);
    wp_n_in = 1'b1;
    tick(4);
    wr(8'h40);
    wait_idle();
    chk8(status_out, 8'h40);
    cmd(OPC_WRITE_ENABLE);
    op(OP_BLOCK_ERASE, 24'hff0000, 1'b0);
    op(OP_HALF_BLOCK_ERASE, 24'hfe8000, 1'b1);
    op(OP_CHIP_ERASE, 24'h000000, 1'b0);
    wr(8'h08);
    wait_idle();
    cmd(OPC_WRITE_ENABLE);
    op(OP_QUAD_PAGE_PROGRAM, 24'hfe0000, 1'b0);
    op(OP_PAGE_PROGRAM, 24'hfd0000, 1'b1);
    $display("test protect done");
  endtask : t_hwp
  task automatic t_otp;
    quad_mode_in = 1'b1;
    tick(3);
    chk1(pin_mode_out == PIN_DATA_IO, 1'b1);
    quad_mode_in = 1'b0;
    otp_mode_enter_in = 1'b1;
    tick(1);
    otp_mode_enter_in = 1'b0;
    tick(2);
    chk1(otp_mode_out, 1'b1);
    cmd(OPC_WRITE_ENABLE);
    wr(8'h7c);
    wait_idle();
    chk8(status_out, 8'h78);
    chk1(pin_mode_out == PIN_DATA_IO, 1'b1);
    cmd(OPC_WRITE_ENABLE);
    op_otp = 1'b1;
    op(OP_SECTOR_ERASE, 24'h000000, 1'b1);
    wr(8'h80);
    wait_idle();
    chk8(status_out, 8'hf8);
    cmd(OPC_WRITE_ENABLE);
    op(OP_SECTOR_ERASE, 24'h000000, 1'b0);
    op_otp = 1'b0;
    cmd(OPC_WRITE_DISABLE);
    chk1(otp_mode_out, 1'b0);
    otp_mode_enter_in = 1'b1;
    tick(1);
    otp_mode_enter_in = 1'b0;
    cmd(OPC_VOLATILE_ENABLE);
    wr(8'h20);
    chk1(pin_mode_out == PIN_RESET, 1'b1);
    hold_reset_n_in = 1'b0;
    tick(3);
    chk1(device_reset_out, 1'b1);
    hold_reset_n_in = 1'b1;
    tick(1);
    chk1(otp_mode_out, 1'b0);
    chk1(pin_mode_out == PIN_DATA_IO, 1'b1);
    $display("test otp done");
  endtask : t_otp

  initial begin
    tick(4);
    rstn_in = 1'b1;
    tick(4);
    t_latch();
    t_nvw();
    t_vol();
    t_hwp();
    t_otp();
    conclude();
  end
endmodule : tb_fsp_top
